// File: csp_bench.sv
// Bench for both ends of the codec control port joined by csp_if.
// Assumes csp_pkg constants; software side reached over APB only.
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module csp_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, gpio_level;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] reference_impedance_select;
    logic analogue_bias_enable, unused_io_buffer_enable, dc_output_buffer_enable;
    logic dac_soft_mute, dac_oversample_select, adc_oversample_select, word_stb;
    logic [8:0] power_control_one, dac_control, adc_control;
    logic [15:0] last_word;
    int checks = 0;
    int n_mismatch = 0;
    int n_stb = 0;
    int cyc = 0;

    csp_if link ();
    csp_host i_csp_host (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    csp_dev i_csp_dev (.clk(clk), .srst(srst), .link(link), .gpio_level(gpio_level),
        .gpio_drive(1'h1), .reference_impedance_select(reference_impedance_select),
        .analogue_bias_enable(analogue_bias_enable),
        .unused_io_buffer_enable(unused_io_buffer_enable),
        .dc_output_buffer_enable(dc_output_buffer_enable), .dac_soft_mute(dac_soft_mute),
        .dac_oversample_select(dac_oversample_select),
        .adc_oversample_select(adc_oversample_select), .power_control_one(power_control_one),
        .dac_control(dac_control), .adc_control(adc_control), .word_stb(word_stb),
        .last_word(last_word));
    csp_properties i_csp_properties (.clk(clk), .srst(srst), .sclk(link.sclk),
        .mode_pin(link.mode_pin), .serial_data_pin(link.serial_data_pin),
        .latch_strobe_pin(link.latch_strobe_pin), .dev_sd_oe(link.dev_sd_oe),
        .dev_lat_oe(link.dev_lat_oe));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (word_stb === 1'h1) n_stb <= n_stb + 1;
        cyc <= cyc + 1;
        // A hung link would otherwise stall the whole run
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Entered just after a rising edge; leaves one edge after release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) begin
            @(posedge clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic send(input logic [15:0] w);
        logic [31:0] q;
        logic e;
        int n;
        apb(1'h1, csp_pkg::HOST_WORD, {16'h0000, w}, q, e);
        q = 32'h0000_0001;
        n = 0;
        while (q[csp_pkg::STAT_BUSY_BIT] !== 1'h0 && n < 400) begin
            apb(1'h0, csp_pkg::HOST_STATUS, 32'h0000_0000, q, e);
            n++;
        end
        `CHK("busy", 1'h0, q[csp_pkg::STAT_BUSY_BIT])
        `CHK("nack", 1'h0, q[csp_pkg::STAT_NACK_BIT])
        repeat (4) @(posedge clk);
    endtask

    task automatic chk_regs(input logic [8:0] p, input logic [8:0] d, input logic [8:0] a);
        `CHK("power", p, power_control_one)
        `CHK("dac", d, dac_control)
        `CHK("adc", a, adc_control)
    endtask

    task automatic t_reset();
        chk_regs(csp_pkg::POWER_ONE_RST, csp_pkg::DAC_CTL_RST, csp_pkg::ADC_CTL_RST);
        `CHK("osr", 1'h0, dac_oversample_select)
        `CHK("adc osr", 1'h0, adc_oversample_select)
        `CHK("mid_rail_reference", 2'h0, reference_impedance_select)
        `CHK("bias", 1'h0, analogue_bias_enable)
        $display("t_reset done");
    endtask

    task automatic t_two_wire();
        int s;
        s = n_stb;
        for (int v = 0; v < 4; v++) begin
            send({csp_pkg::RA_POWER_ONE, 9'h008 | 9'(v)});
            `CHK("mid_rail_reference", 2'(v), reference_impedance_select)
            `CHK("bias", 1'h1, analogue_bias_enable)
        end
        send({csp_pkg::RA_POWER_ONE, 9'h104});
        `CHK("dcop", 1'h1, dc_output_buffer_enable)
        `CHK("bias", 1'h0, analogue_bias_enable)
        `CHK("bufio", 1'h1, unused_io_buffer_enable)
        send({csp_pkg::RA_DAC_CTL, 9'h048});
        send({csp_pkg::RA_ADC_CTL, 9'h008});
        `CHK("dac osr", 1'h1, dac_oversample_select)
        `CHK("mute", 1'h1, dac_soft_mute)
        `CHK("adc osr", 1'h1, adc_oversample_select)
        chk_regs(9'h104, 9'h048, 9'h008);
        `CHK("word", {csp_pkg::RA_ADC_CTL, 9'h008}, last_word)
        `CHK("strobes", 7, n_stb - s)
        $display("t_two_wire done");
    endtask

    task automatic t_unmapped_and_reset();
        send({7'h03, 9'h1ff});
        `CHK("word", {7'h03, 9'h1ff}, last_word)
        chk_regs(9'h104, 9'h048, 9'h008);
        send({csp_pkg::RA_SOFT_RESET, 9'h155});
        chk_regs(csp_pkg::POWER_ONE_RST, csp_pkg::DAC_CTL_RST, csp_pkg::ADC_CTL_RST);
        $display("t_unmapped_and_reset done");
    endtask

    task automatic t_three_wire();
        logic [31:0] q;
        logic e;
        apb(1'h1, csp_pkg::HOST_CTRL, 32'h0000_0001, q, e);
        repeat (4) @(posedge clk);
        send({csp_pkg::RA_DAC_CTL, 9'h008});
        send({csp_pkg::RA_POWER_ONE, 9'h003});
        `CHK("dac osr", 1'h1, dac_oversample_select)
        chk_regs(9'h003, 9'h008, csp_pkg::ADC_CTL_RST);
        `CHK("word", {csp_pkg::RA_POWER_ONE, 9'h003}, last_word)
        // Codec must not pull the strobe while the controller owns it
        gpio_level <= 1'h0;
        repeat (4) @(posedge clk);
        `CHK("gpio 3w", 1'h1, link.latch_strobe_pin)
        gpio_level <= 1'h1;
        @(posedge clk);
        apb(1'h1, csp_pkg::HOST_CTRL, 32'h0000_0000, q, e);
        repeat (4) @(posedge clk);
        $display("t_three_wire done");
    endtask

    task automatic t_apb_gpio();
        logic [31:0] q;
        logic e;
        apb(1'h0, 8'h0c, 32'h0000_0000, q, e);
        `CHK("slverr", 1'h1, e)
        `CHK("rdata", 32'h0000_0000, q)
        apb(1'h0, csp_pkg::HOST_WORD, 32'h0000_0000, q, e);
        `CHK("readback", {16'h0000, csp_pkg::RA_POWER_ONE, 9'h003}, q)
        gpio_level <= 1'h0;
        repeat (4) @(posedge clk);
        `CHK("gpio", 1'h0, link.latch_strobe_pin)
        gpio_level <= 1'h1;
        @(posedge clk);
        $display("t_apb_gpio done");
    endtask

    initial begin
        srst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        gpio_level = 1'h1;
        repeat (6) @(posedge clk);
        srst <= 1'h0;
        // Device synchronisers settle before the first word
        repeat (3) @(posedge clk);
        t_reset();
        t_two_wire();
        t_unmapped_and_reset();
        t_three_wire();
        t_apb_gpio();
        tally_and_finish();
    end
endmodule

// File: csp_dev.sv
// Codec end: write-only serial control port with its control registers.
// Assumes link pins are asynchronous to clk and slower than clk / 8.
//
// Chosen here: registers written over the serial link only; APB sits in csp_host.
module csp_dev (
    input wire logic clk,
    input wire logic srst,
    csp_if.dev link,
    input wire logic gpio_level,
    input wire logic gpio_drive,
    output logic [1:0] reference_impedance_select,
    output logic analogue_bias_enable,
    output logic unused_io_buffer_enable,
    output logic dc_output_buffer_enable,
    output logic dac_soft_mute,
    output logic dac_oversample_select,
    output logic adc_oversample_select,
    output logic [8:0] power_control_one,
    output logic [8:0] dac_control,
    output logic [8:0] adc_control,
    output logic word_stb,
    output logic [15:0] last_word
);
    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] sd_s;
        logic [2:0] lat_s;
        logic [1:0] mode_s;
        csp_pkg::csp_dstate_e state;
        logic [3:0] bitcnt;
        logic [1:0] byte_idx;
        logic [7:0] sh;
        logic [7:0] hi;
        logic [15:0] sr3;
        logic ack_oe;
        logic [8:0] pwr1;
        logic [8:0] dac;
        logic [8:0] adc;
        logic wr_stb;
        logic [15:0] word;
    } csp_dev_s;

    csp_dev_s s_ff, nxt_s;
    logic sck_rise, sck_fall, sck_high, lat_rise, start_cond, stop_cond, mode_3w;

    // Commits one control word; shared by both link modes
    function automatic csp_dev_s commit(input csp_dev_s cur, input logic [15:0] w);
        csp_dev_s r;
        r = cur;
        r.wr_stb = 1'b1;
        r.word = w;
        case (w[15:9])
            csp_pkg::RA_SOFT_RESET: begin
                r.pwr1 = csp_pkg::POWER_ONE_RST;
                r.dac = csp_pkg::DAC_CTL_RST;
                r.adc = csp_pkg::ADC_CTL_RST;
            end
            csp_pkg::RA_POWER_ONE: r.pwr1 = w[8:0];
            csp_pkg::RA_DAC_CTL: r.dac = w[8:0];
            csp_pkg::RA_ADC_CTL: r.adc = w[8:0];
            default: r.word = w;
        endcase
        return r;
    endfunction

    // Edges judged from second flop against a third; first flop feeds only the second
    assign sck_rise = s_ff.sclk_s[1] & ~s_ff.sclk_s[2];
    assign sck_fall = ~s_ff.sclk_s[1] & s_ff.sclk_s[2];
    assign sck_high = s_ff.sclk_s[1] & s_ff.sclk_s[2];
    assign lat_rise = s_ff.lat_s[1] & ~s_ff.lat_s[2];
    assign start_cond = sck_high & s_ff.sd_s[2] & ~s_ff.sd_s[1];
    assign stop_cond = sck_high & ~s_ff.sd_s[2] & s_ff.sd_s[1];
    assign mode_3w = s_ff.mode_s[1];

    always_comb begin
        nxt_s = s_ff;
        nxt_s.wr_stb = 1'b0;
        nxt_s.sclk_s = {s_ff.sclk_s[1:0], link.sclk};
        nxt_s.sd_s = {s_ff.sd_s[1:0], link.serial_data_pin};
        nxt_s.lat_s = {s_ff.lat_s[1:0], link.latch_strobe_pin};
        nxt_s.mode_s = {s_ff.mode_s[0], link.mode_pin};
        if (mode_3w) begin
            nxt_s.state = csp_pkg::D_IDLE;
            nxt_s.ack_oe = 1'b0;
            if (sck_rise) begin
                nxt_s.sr3 = {s_ff.sr3[14:0], s_ff.sd_s[1]};
            end
            // Strobe with a clock edge commits the bits shifted before it
            if (lat_rise) begin
                nxt_s = commit(nxt_s, s_ff.sr3);
            end
        end else if (start_cond) begin
            nxt_s.state = csp_pkg::D_SHIFT;
            nxt_s.bitcnt = 4'h0;
            nxt_s.byte_idx = 2'h0;
            nxt_s.ack_oe = 1'b0;
        end else if (stop_cond) begin
            nxt_s.state = csp_pkg::D_IDLE;
            nxt_s.ack_oe = 1'b0;
        end else begin
            case (s_ff.state)
                csp_pkg::D_SHIFT: begin
                    if (sck_rise && s_ff.bitcnt != 4'h8) begin
                        nxt_s.sh = {s_ff.sh[6:0], s_ff.sd_s[1]};
                        nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
                    end
                    if (sck_fall && s_ff.bitcnt == 4'h8) begin
                        nxt_s.ack_oe = 1'b1;
                        nxt_s.state = csp_pkg::D_ACK;
                        case (s_ff.byte_idx)
                            2'h0: begin
                                // Read requests are not served; port is write-only
                                if (s_ff.sh[7:1] != csp_pkg::DEV_ADDR || s_ff.sh[0]) begin
                                    nxt_s.ack_oe = 1'b0;
                                    nxt_s.state = csp_pkg::D_IDLE;
                                end
                            end
                            2'h1: nxt_s.hi = s_ff.sh;
                            default: nxt_s = commit(nxt_s, {s_ff.hi, s_ff.sh});
                        endcase
                    end
                end
                csp_pkg::D_ACK: begin
                    if (sck_fall) begin
                        nxt_s.ack_oe = 1'b0;
                        nxt_s.bitcnt = 4'h0;
                        if (s_ff.byte_idx == 2'h2) begin
                            nxt_s.state = csp_pkg::D_WAIT;
                        end else begin
                            nxt_s.byte_idx = s_ff.byte_idx + 2'h1;
                            nxt_s.state = csp_pkg::D_SHIFT;
                        end
                    end
                end
                csp_pkg::D_WAIT: nxt_s.state = csp_pkg::D_WAIT;
                default: begin
                    nxt_s.state = csp_pkg::D_IDLE;
                    nxt_s.ack_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_ff <= '0;
            s_ff.sclk_s <= 3'h7;
            s_ff.sd_s <= 3'h7;
            s_ff.lat_s <= 3'h7;
            s_ff.pwr1 <= csp_pkg::POWER_ONE_RST;
            s_ff.dac <= csp_pkg::DAC_CTL_RST;
            s_ff.adc <= csp_pkg::ADC_CTL_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign reference_impedance_select = s_ff.pwr1[csp_pkg::MID_RAIL_REFERENCE_SEL_LSB +: 2];
    assign analogue_bias_enable = s_ff.pwr1[csp_pkg::BIAS_BIT];
    assign unused_io_buffer_enable = s_ff.pwr1[csp_pkg::BUF_IO_BIT];
    assign dc_output_buffer_enable = s_ff.pwr1[csp_pkg::BUF_DCOP_BIT];
    assign dac_soft_mute = s_ff.dac[csp_pkg::DAC_MUTE_BIT];
    assign dac_oversample_select = s_ff.dac[csp_pkg::DAC_OSR_BIT];
    assign adc_oversample_select = s_ff.adc[csp_pkg::ADC_OSR_BIT];
    assign power_control_one = s_ff.pwr1;
    assign dac_control = s_ff.dac;
    assign adc_control = s_ff.adc;
    assign word_stb = s_ff.wr_stb;
    assign last_word = s_ff.word;

    // Acknowledge only pulls low; never drives a high level onto the shared line
    assign link.dev_sd_o = 1'b0;
    assign link.dev_sd_oe = s_ff.ack_oe;
    assign link.dev_lat_o = gpio_level;
    assign link.dev_lat_oe = ~mode_3w & gpio_drive;
endmodule

// File: csp_host.sv
// Controller end: APB slave that sends 16-bit control words on the link.
// Assumes software orders its words; link pins reach the codec by csp_if.
module csp_host (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    csp_if.host link
);
    typedef struct packed {
        csp_pkg::csp_hstate_e state;
        logic [7:0] qcnt;
        logic [1:0] q;
        logic [23:0] tx;
        logic [4:0] cnt;
        logic [3:0] bib;
        logic [1:0] sd_s;
        logic sclk;
        logic sd_o;
        logic sd_oe;
        logic lat_o;
        logic mode3w;
        logic nack;
        logic [15:0] word;
        logic [31:0] rdata;
    } csp_host_s;

    csp_host_s s_ff, nxt_s;
    logic tick, ack_slot, wr, hit;

    assign tick = (s_ff.qcnt == 8'(csp_pkg::QTR_CYC - 1));
    assign ack_slot = ~s_ff.mode3w && (s_ff.bib == 4'h8);
    assign wr = psel & penable & pwrite;
    assign hit = (paddr == csp_pkg::HOST_CTRL) || (paddr == csp_pkg::HOST_WORD)
        || (paddr == csp_pkg::HOST_STATUS);

    always_comb begin
        nxt_s = s_ff;
        nxt_s.sd_s = {s_ff.sd_s[0], link.serial_data_pin};
        nxt_s.qcnt = tick ? 8'h00 : s_ff.qcnt + 8'h01;
        if (psel & ~penable) begin
            case (paddr)
                csp_pkg::HOST_CTRL: nxt_s.rdata = {31'h0, s_ff.mode3w};
                csp_pkg::HOST_WORD: nxt_s.rdata = {16'h0, s_ff.word};
                csp_pkg::HOST_STATUS:
                    nxt_s.rdata = {30'h0, s_ff.nack, s_ff.state != csp_pkg::H_IDLE};
                default: nxt_s.rdata = 32'h0;
            endcase
        end
        if (wr && paddr == csp_pkg::HOST_CTRL && s_ff.state == csp_pkg::H_IDLE) begin
            nxt_s.mode3w = pwdata[csp_pkg::CTRL_MODE_BIT];
            nxt_s.lat_o = 1'b1;
        end
        if (tick && s_ff.state != csp_pkg::H_IDLE) begin
            nxt_s.q = s_ff.q + 2'h1;
        end
        case (s_ff.state)
            csp_pkg::H_IDLE: begin
                // Words are taken only while idle; one written during a transfer is dropped
                if (wr && paddr == csp_pkg::HOST_WORD) begin
                    nxt_s.word = pwdata[15:0];
                    nxt_s.nack = 1'b0;
                    nxt_s.q = 2'h0;
                    nxt_s.qcnt = 8'h00;
                    nxt_s.bib = 4'h0;
                    if (s_ff.mode3w) begin
                        nxt_s.tx = {pwdata[15:0], 8'h00};
                        nxt_s.cnt = 5'(csp_pkg::SLOTS_3W);
                        nxt_s.sclk = 1'b0;
                        nxt_s.lat_o = 1'b0;
                        nxt_s.state = csp_pkg::H_BITS;
                    end else begin
                        nxt_s.tx = {csp_pkg::DEV_ADDR, 1'b0, pwdata[15:0]};
                        nxt_s.cnt = 5'(csp_pkg::SLOTS_2W);
                        nxt_s.state = csp_pkg::H_START;
                    end
                end
            end
            csp_pkg::H_START: if (tick) begin
                if (s_ff.q == 2'h0) begin
                    nxt_s.sd_oe = 1'b1;
                    nxt_s.sd_o = 1'b0;
                end else begin
                    nxt_s.sclk = 1'b0;
                    nxt_s.q = 2'h0;
                    nxt_s.state = csp_pkg::H_BITS;
                end
            end
            csp_pkg::H_BITS: if (tick) begin
                case (s_ff.q)
                    2'h0: begin
                        nxt_s.sd_oe = ~ack_slot;
                        nxt_s.sd_o = s_ff.tx[23];
                    end
                    2'h1: nxt_s.sclk = 1'b1;
                    2'h2: if (ack_slot && s_ff.sd_s[1]) nxt_s.nack = 1'b1;
                    default: begin
                        nxt_s.sclk = 1'b0;
                        nxt_s.cnt = s_ff.cnt - 5'h1;
                        if (ack_slot) begin
                            nxt_s.bib = 4'h0;
                        end else begin
                            nxt_s.tx = {s_ff.tx[22:0], 1'b0};
                            nxt_s.bib = s_ff.bib + 4'h1;
                        end
                        if (s_ff.cnt == 5'h1 || s_ff.nack) begin
                            nxt_s.state = s_ff.mode3w ? csp_pkg::H_LATCH : csp_pkg::H_STOP;
                        end
                    end
                endcase
            end
            csp_pkg::H_STOP: if (tick) begin
                case (s_ff.q)
                    2'h0: begin
                        nxt_s.sd_oe = 1'b1;
                        nxt_s.sd_o = 1'b0;
                    end
                    2'h1: nxt_s.sclk = 1'b1;
                    2'h2: nxt_s.sd_oe = 1'b0;
                    default: nxt_s.state = csp_pkg::H_IDLE;
                endcase
            end
            csp_pkg::H_LATCH: if (tick) begin
                if (s_ff.q == 2'h0) begin
                    nxt_s.lat_o = 1'b1;
                end else begin
                    nxt_s.sclk = 1'b1;
                    nxt_s.sd_oe = 1'b0;
                    nxt_s.state = csp_pkg::H_IDLE;
                end
            end
            default: nxt_s.state = csp_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_ff <= '0;
            s_ff.sclk <= 1'b1;
            s_ff.lat_o <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata = s_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign link.sclk = s_ff.sclk;
    assign link.mode_pin = s_ff.mode3w;
    assign link.host_sd_o = s_ff.sd_o;
    assign link.host_sd_oe = s_ff.sd_oe;
    assign link.host_lat_o = s_ff.lat_o;
    // Strobe is left to the codec's general output in 2-wire mode
    assign link.host_lat_oe = s_ff.mode3w;
endmodule

// File: csp_if.sv
// Pins between the codec control port and its controller.
// Assumes pull-ups on data and strobe; every driver on those two is wired-and.
interface csp_if;
    logic sclk;
    logic mode_pin;
    logic host_sd_o;
    logic host_sd_oe;
    logic dev_sd_o;
    logic dev_sd_oe;
    logic host_lat_o;
    logic host_lat_oe;
    logic dev_lat_o;
    logic dev_lat_oe;
    logic serial_data_pin;
    logic latch_strobe_pin;

    assign serial_data_pin = (~host_sd_oe | host_sd_o) & (~dev_sd_oe | dev_sd_o);
    assign latch_strobe_pin = (~host_lat_oe | host_lat_o) & (~dev_lat_oe | dev_lat_o);

    modport dev (
        input sclk,
        input mode_pin,
        input serial_data_pin,
        input latch_strobe_pin,
        output dev_sd_o,
        output dev_sd_oe,
        output dev_lat_o,
        output dev_lat_oe
    );
    modport host (
        output sclk,
        output mode_pin,
        output host_sd_o,
        output host_sd_oe,
        output host_lat_o,
        output host_lat_oe,
        input serial_data_pin,
        input latch_strobe_pin
    );
endinterface

// File: csp_pkg.sv
// Constants and types shared by both ends of the codec control port.
// Assumes a 40 MHz system clock on both ends and a pulled-up link.
package csp_pkg;
    localparam int WORD_W = 16;
    localparam int RADDR_W = 7;
    localparam int RDATA_W = 9;

    // Register addresses inside the codec
    localparam logic [6:0] RA_SOFT_RESET = 7'h00;
    localparam logic [6:0] RA_POWER_ONE = 7'h01;
    localparam logic [6:0] RA_DAC_CTL = 7'h0a;
    localparam logic [6:0] RA_ADC_CTL = 7'h0e;

    // Reset values
    localparam logic [8:0] POWER_ONE_RST = 9'h000;
    localparam logic [8:0] DAC_CTL_RST = 9'h000;
    localparam logic [8:0] ADC_CTL_RST = 9'h100;

    // Field positions
    localparam int MID_RAIL_REFERENCE_SEL_LSB = 0;
    localparam int BUF_IO_BIT = 2;
    localparam int BIAS_BIT = 3;
    localparam int BUF_DCOP_BIT = 8;
    localparam int DAC_MUTE_BIT = 6;
    localparam int DAC_OSR_BIT = 3;
    localparam int ADC_OSR_BIT = 3;

    // Fixed 2-wire slave address
    localparam logic [6:0] DEV_ADDR = 7'h1a;

    // Link timing made by the controller
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCLK_PERIOD_NS = 400;
    localparam int QTR_CYC = SCLK_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int SLOTS_2W = 27;
    localparam int SLOTS_3W = 16;

    // Controller APB register offsets
    localparam logic [7:0] HOST_CTRL = 8'h00;
    localparam logic [7:0] HOST_WORD = 8'h04;
    localparam logic [7:0] HOST_STATUS = 8'h08;
    localparam int CTRL_MODE_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;

    typedef enum logic [1:0] {D_IDLE, D_SHIFT, D_ACK, D_WAIT} csp_dstate_e;
    typedef enum logic [2:0] {H_IDLE, H_START, H_BITS, H_STOP, H_LATCH} csp_hstate_e;
endpackage

// File: csp_properties.sv
// Checker on the link pins between the codec port and its controller.
// Assumes csp_bench instantiates it beside the interface; no bind.
module csp_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic mode_pin,
    input wire logic serial_data_pin,
    input wire logic latch_strobe_pin,
    input wire logic dev_sd_oe,
    input wire logic dev_lat_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Data moving while the clock stays high frames a transfer
    sequence start_cond;
        !mode_pin && sclk && $past(sclk) && $fell(serial_data_pin);
    endsequence

    sequence stop_cond;
        !mode_pin && sclk && $past(sclk) && $rose(serial_data_pin);
    endsequence

    a_addr_ack_time: assert property (start_cond |-> ##[100:200] dev_sd_oe)
        else $error("address ack missing after start");
    a_ack_pulls_low: assert property (dev_sd_oe |-> !serial_data_pin)
        else $error("ack does not hold data low");
    a_ack_clock_low: assert property ($rose(dev_sd_oe) |-> !sclk)
        else $error("ack raised while clock high");
    a_ack_no_stop: assert property (sclk && $past(sclk) |-> !$fell(dev_sd_oe))
        else $error("ack released while clock high");
    a_ack_one_pulse: assert property ($rose(dev_sd_oe) |-> ##[8:24] $fell(dev_sd_oe))
        else $error("ack not one clock pulse long");
    a_stop_idle: assert property (stop_cond |-> !dev_sd_oe [*8])
        else $error("ack seen after stop");
    a_ack_two_wire: assert property (mode_pin [*4] |-> !dev_sd_oe)
        else $error("ack driven in three-wire mode");
    // Strobe pin belongs to the controller in three-wire mode
    a_gpio_two_wire: assert property (mode_pin [*4] |-> !dev_lat_oe)
        else $error("strobe driven in three-wire mode");
endmodule
